/* File: rtl/dtiu_pkg.sv */
// Purpose: shared constants and types for the data transfer instruction unit
// Assumes: decoded operations arrive one at a time from the instruction sequencer
// Notes: register codes use bit 3 to pick the low byte of a 16-bit register
package dtiu_pkg;
  // operation kinds
  typedef enum logic [1:0] {
    DTIU_OP_MOVE,
    DTIU_OP_PUSH,
    DTIU_OP_POP
  } dtiu_op_t;
  // addressing modes
  typedef enum logic [2:0] {
    DTIU_M_REG,
    DTIU_M_IND,
    DTIU_M_DISP,
    DTIU_M_ABS16,
    DTIU_M_ABS8,
    DTIU_M_IMM,
    DTIU_M_PREDEC,
    DTIU_M_POSTINC
  } dtiu_mode_t;
  localparam logic [15:0] DTIU_BYTE_STEP = 16'h0001;
  localparam logic [15:0] DTIU_WORD_STEP = 16'h0002;
  localparam logic [7:0] DTIU_ABS8_PAGE = 8'hff;
  localparam logic [2:0] DTIU_STACK_GPR = 3'h7;
  localparam logic [15:0] DTIU_REG_RESET = 16'h0000;
  // condition flag bit positions
  localparam int DTIU_FLAG_C = 0;
  localparam int DTIU_FLAG_V = 1;
  localparam int DTIU_FLAG_Z = 2;
  localparam int DTIU_FLAG_N = 3;
  localparam logic [3:0] DTIU_FLAGS_RESET = 4'h0;
endpackage : dtiu_pkg

/* File: rtl/dtiu_unit.sv */
// Purpose: executes decoded move, push and pop operations on the register file and memory bus
// Assumes: one memory access per operation; memory answers with a one-cycle ack
// Notes: eight 16-bit registers are held here; register 7 is the stack pointer
`timescale 1ns/10ps
module dtiu_unit
  import dtiu_pkg::*;
#(
  parameter int NUM_REGS = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // decoded operation
  input wire logic op_valid_in,
  output logic op_ready_out,
  input wire dtiu_op_t op_kind_in,
  input wire logic op_word_in,
  input wire dtiu_mode_t op_mode_in,
  input wire logic op_store_in,
  input wire logic [3:0] op_reg_in,
  input wire logic [3:0] op_src_in,
  input wire logic [15:0] op_ext_in,
  // completion
  output logic done_out,
  output logic illegal_out,
  // memory bus
  output logic mem_req_out,
  output logic mem_we_out,
  output logic mem_word_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  // observation
  input wire logic [2:0] reg_rd_sel_in,
  output logic [15:0] reg_rd_data_out,
  output logic [3:0] condition_flags_out
);

  // only a 3-bit register field is decoded, so other sizes are refused at elaboration
  if (NUM_REGS != 8) begin : g_bad_regs
    $error("dtiu_unit: register field is 3 bits, NUM_REGS must be 8");
  end

  typedef enum logic [1:0] {DTIU_S_IDLE, DTIU_S_MEM, DTIU_S_DONE} dtiu_state_t;

  // byte select from a register code
  function automatic logic [7:0] dtiu_byte(input logic [15:0] w, input logic lo);
    dtiu_byte = lo ? w[7:0] : w[15:8];
  endfunction : dtiu_byte

  logic [15:0] regs_q [NUM_REGS];
  dtiu_state_t state_q;
  logic word_q, store_q, done_q, illegal_q;
  dtiu_mode_t mode_q;
  logic [3:0] dst_q;
  logic [2:0] ptr_q;
  logic [15:0] ea_q, wdata_q, step_q;
  logic [3:0] flags_q;

  // request decode
  logic accept, legal, is_mem, stack_ptr;
  dtiu_mode_t mode_d;
  logic store_d, word_d;
  logic [2:0] ptr_d;
  logic [15:0] step_d, base_d, ea_d, src_val, imm_val;

  always_comb begin
    mode_d = op_mode_in;
    store_d = op_store_in;
    word_d = op_word_in;
    ptr_d = op_src_in[2:0];
    if (op_kind_in == DTIU_OP_PUSH) begin
      mode_d = DTIU_M_PREDEC;
      store_d = 1'b1;
      word_d = 1'b1;
      ptr_d = DTIU_STACK_GPR;
    end else if (op_kind_in == DTIU_OP_POP) begin
      mode_d = DTIU_M_POSTINC;
      store_d = 1'b0;
      word_d = 1'b1;
      ptr_d = DTIU_STACK_GPR;
    end
  end

  assign stack_ptr = (ptr_d == DTIU_STACK_GPR);
  assign is_mem = !(mode_d inside {DTIU_M_REG, DTIU_M_IMM});
  assign step_d = word_d ? DTIU_WORD_STEP : DTIU_BYTE_STEP;
  assign base_d = regs_q[ptr_d];

  // legality: short absolute is byte only, stack auto-modes word only, no store to immediate
  always_comb begin
    legal = 1'b1;
    if (word_d && mode_d == DTIU_M_ABS8) legal = 1'b0;
    if (!word_d && stack_ptr && mode_d inside {DTIU_M_PREDEC, DTIU_M_POSTINC}) legal = 1'b0;
    if (store_d && mode_d == DTIU_M_IMM) legal = 1'b0;
    if (op_kind_in == DTIU_OP_MOVE && word_d && op_reg_in[3]) legal = 1'b0;
    if (op_kind_in == DTIU_OP_MOVE && word_d && mode_d == DTIU_M_REG && op_src_in[3]) legal = 1'b0;
  end

  // effective address; word accesses drop bit 0
  always_comb begin
    case (mode_d)
      DTIU_M_IND: ea_d = base_d;
      DTIU_M_DISP: ea_d = base_d + op_ext_in;
      DTIU_M_ABS16: ea_d = op_ext_in;
      DTIU_M_ABS8: ea_d = {DTIU_ABS8_PAGE, op_ext_in[7:0]};
      DTIU_M_PREDEC: ea_d = base_d - step_d;
      DTIU_M_POSTINC: ea_d = base_d;
      default: ea_d = 16'h0000;
    endcase
    if (word_d) ea_d[0] = 1'b0;
  end

  // value of the register operand or immediate
  assign src_val = word_d ? regs_q[op_reg_in[2:0]] : {8'h00, dtiu_byte(regs_q[op_reg_in[2:0]], op_reg_in[3])};
  assign imm_val = word_d ? op_ext_in : {8'h00, op_ext_in[7:0]};

  assign op_ready_out = (state_q == DTIU_S_IDLE);
  assign accept = op_valid_in && op_ready_out;

  // operation sequencing
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= DTIU_S_IDLE;
    end else begin
      case (state_q)
        DTIU_S_IDLE: begin
          if (accept && legal) state_q <= is_mem ? DTIU_S_MEM : DTIU_S_DONE;
        end
        DTIU_S_MEM: begin
          if (mem_ack_in) state_q <= DTIU_S_IDLE;
        end
        DTIU_S_DONE: state_q <= DTIU_S_IDLE;
        default: state_q <= DTIU_S_IDLE;
      endcase
    end
  end

  // captured operation
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      word_q <= 1'b0;
      store_q <= 1'b0;
      mode_q <= DTIU_M_REG;
      dst_q <= 4'h0;
      ptr_q <= 3'h0;
      ea_q <= 16'h0000;
      wdata_q <= 16'h0000;
      step_q <= 16'h0000;
    end else if (accept && legal) begin
      word_q <= word_d;
      store_q <= store_d;
      mode_q <= mode_d;
      dst_q <= op_reg_in;
      ptr_q <= ptr_d;
      ea_q <= ea_d;
      wdata_q <= (mode_d == DTIU_M_REG) ? (word_d ? regs_q[op_src_in[2:0]] :
                 {8'h00, dtiu_byte(regs_q[op_src_in[2:0]], op_src_in[3])}) :
                 (mode_d == DTIU_M_IMM) ? imm_val : src_val;
      step_q <= step_d;
    end
  end

  // value moved by the completing operation: loads take bus data, stores and register moves the captured word
  logic [15:0] moved;
  assign moved = (state_q == DTIU_S_MEM && !store_q) ? (word_q ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]}) :
                 wdata_q;
  logic finish;
  assign finish = (state_q == DTIU_S_DONE) || (state_q == DTIU_S_MEM && mem_ack_in);

  // register file: pointer updates, then loaded data (data wins if same register)
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= DTIU_REG_RESET;
    end else begin
      if (accept && legal && mode_d == DTIU_M_PREDEC) regs_q[ptr_d] <= ea_d;
      if (finish && mode_q == DTIU_M_POSTINC) regs_q[ptr_q] <= ea_q + step_q;
      if (finish && !store_q) begin
        if (word_q) regs_q[dst_q[2:0]] <= moved;
        else if (dst_q[3]) regs_q[dst_q[2:0]][7:0] <= moved[7:0];
        else regs_q[dst_q[2:0]][15:8] <= moved[7:0];
      end
    end
  end

  // condition flags: carry untouched
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      flags_q <= DTIU_FLAGS_RESET;
    end else if (finish) begin
      flags_q[DTIU_FLAG_N] <= word_q ? moved[15] : moved[7];
      flags_q[DTIU_FLAG_Z] <= word_q ? (moved == 16'h0000) : (moved[7:0] == 8'h00);
      flags_q[DTIU_FLAG_V] <= 1'b0;
    end
  end

  // completion pulses and observation port
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      reg_rd_data_out <= 16'h0000;
    end else begin
      done_q <= finish;
      illegal_q <= accept && !legal;
      reg_rd_data_out <= regs_q[reg_rd_sel_in];
    end
  end

  assign done_out = done_q;
  assign illegal_out = illegal_q;
  assign condition_flags_out = flags_q;
  assign mem_req_out = (state_q == DTIU_S_MEM);
  assign mem_we_out = mem_req_out && store_q;
  assign mem_word_out = word_q;
  assign mem_addr_out = ea_q;
  assign mem_wdata_out = wdata_q;

  // checks
  default clocking dtiu_cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_push_req;
    op_valid_in && op_ready_out && op_kind_in == DTIU_OP_PUSH;
  endsequence
  sequence s_store_word;
    mem_req_out && mem_we_out && mem_word_out;
  endsequence
  sequence s_pop_req;
    op_valid_in && op_ready_out && op_kind_in == DTIU_OP_POP;
  endsequence
  sequence s_pop_ack;
    mem_req_out && !mem_we_out && mem_word_out && mem_ack_in && mode_q == DTIU_M_POSTINC
      && ptr_q == DTIU_STACK_GPR;
  endsequence

  a_abs8_word: assert property (accept && word_d && mode_d == DTIU_M_ABS8 |=> illegal_out && !mem_req_out)
    else $error("word move with short absolute was not refused");
  a_stack_byte: assert property (accept && op_kind_in == DTIU_OP_MOVE && !op_word_in
    && op_src_in[2:0] == 3'h7 && op_mode_in inside {DTIU_M_PREDEC, DTIU_M_POSTINC} |=> illegal_out)
    else $error("byte auto-mode through stack register was not refused");
  a_abs8_page: assert property (mem_req_out && mode_q == DTIU_M_ABS8 |-> mem_addr_out[15:8] == 8'hff)
    else $error("short absolute address not in top page");
  a_word_even: assert property (mem_req_out && mem_word_out |-> !mem_addr_out[0])
    else $error("word access at odd address");
  a_push_order: assert property (s_push_req |=> s_store_word
    ##0 (regs_q[7] == $past(regs_q[7]) - 16'h0002) ##0 (mem_addr_out == regs_q[7]))
    else $error("push did not pre-decrement and store at new pointer");
  a_pop_read: assert property (s_pop_req |=> mem_req_out && !mem_we_out && mem_word_out
    && mem_addr_out == ($past(regs_q[7]) & 16'hfffe))
    else $error("pop did not read at the stack pointer");
  a_pop_order: assert property (s_pop_ack |=> regs_q[7] == $past(mem_addr_out) + 16'h0002
    || dst_q[2:0] == 3'h7)
    else $error("pop did not advance pointer by two");
  a_byte_step: assert property (accept && legal && !word_d && mode_d == DTIU_M_PREDEC && ptr_d != 3'h7
    |=> regs_q[ptr_q] == $past(base_d) - 16'h0001)
    else $error("byte pre-decrement step wrong");
  a_flags_move: assert property (finish |=> !condition_flags_out[1] && $stable(condition_flags_out[0]))
    else $error("move changed carry or left overflow set");
  a_done_after: assert property (mem_req_out && mem_ack_in |=> done_out && op_ready_out)
    else $error("memory move did not complete one cycle after ack");
endmodule : dtiu_unit

/* File: bench/dtiu_mem_model.sv */
// Purpose: behavioural memory that answers the unit's bus
// Assumes: one request at a time, held until its ack
// Notes: read data toggles every cycle outside an answer
`timescale 1ns/10ps
module dtiu_mem_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // bus from the unit, and the ack latency set by the bench
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic [15:0] mem_wdata_in,
  input wire logic [3:0] lat_in,
  // answer
  output logic mem_ack_out,
  output logic [15:0] mem_rdata_out
);
  logic [15:0] mem_q [logic [15:0]];
  logic [3:0] wait_q = 4'h0;
  initial mem_ack_out = 1'b0;
  initial mem_rdata_out = 16'h5a5a;
  // ack after lat_in idle cycles, one cycle long
  always @(posedge clock_in) begin
    #1;
    mem_rdata_out = ~mem_rdata_out;
    if (rst_in || !mem_req_in || mem_ack_out) begin
      mem_ack_out = 1'b0;
      wait_q = 4'h0;
    end else if (wait_q == lat_in) begin
      mem_ack_out = 1'b1;
      if (mem_we_in) mem_q[mem_addr_in] = mem_wdata_in;
      else mem_rdata_out = mem_q.exists(mem_addr_in) ? mem_q[mem_addr_in] : 16'h0000;
    end else wait_q = wait_q + 4'h1;
  end
endmodule : dtiu_mem_model

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the data transfer unit
// Assumes: memory model answers every request
// Notes: registers are seen through the view port
`timescale 1ns/10ps
module tb_top;
  import dtiu_pkg::*;
  logic clock_in = 0, rst_in = 1, op_valid_in = 0, op_word_in = 0, op_store_in = 0;
  dtiu_op_t op_kind_in = DTIU_OP_MOVE;
  dtiu_mode_t op_mode_in = DTIU_M_REG;
  logic [3:0] op_reg_in = 4'h0, op_src_in = 4'h0, lat = 4'h0, condition_flags_out;
  logic [15:0] op_ext_in = 16'h0000, mem_addr_out, mem_wdata_out, mem_rdata_in, reg_rd_data_out, seen_addr;
  logic [2:0] reg_rd_sel_in = 3'h0;
  logic op_ready_out, done_out, illegal_out, mem_req_out, mem_we_out, mem_ack_in, seen_we;
  logic mem_word_out, seen_word;
  int n_errors = 0, samples_checked = 0;
  // clock
  always #5 clock_in = ~clock_in;
  // unit and memory
  dtiu_unit uut (.clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_valid_in), .op_ready_out(op_ready_out),
    .op_kind_in(op_kind_in), .op_word_in(op_word_in), .op_mode_in(op_mode_in), .op_store_in(op_store_in),
    .op_reg_in(op_reg_in), .op_src_in(op_src_in), .op_ext_in(op_ext_in), .done_out(done_out),
    .illegal_out(illegal_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_word_out(mem_word_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in), .reg_rd_sel_in(reg_rd_sel_in), .reg_rd_data_out(reg_rd_data_out),
    .condition_flags_out(condition_flags_out));
  dtiu_mem_model mem (.clock_in(clock_in), .rst_in(rst_in), .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
    .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .lat_in(lat), .mem_ack_out(mem_ack_in),
    .mem_rdata_out(mem_rdata_in));
  // remember the last answered access
  always @(posedge clock_in) if (mem_ack_in) begin
    seen_addr <= mem_addr_out;
    seen_we <= mem_we_out;
    seen_word <= mem_word_out;
  end
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // one operation, waits for done or refusal
  task automatic op(input dtiu_op_t k, input logic w, input dtiu_mode_t m, input logic s,
      input logic [3:0] r, input logic [3:0] p, input logic [15:0] x, input logic ill);
    int i;
    int j;
    @(posedge clock_in);
    #1;
    {op_valid_in, op_kind_in, op_word_in, op_mode_in, op_store_in} = {1'b1, k, w, m, s};
    {op_reg_in, op_src_in, op_ext_in} = {r, p, x};
    for (i = 0; i < 40 && op_ready_out !== 1'b1; i++) @(negedge clock_in);
    @(posedge clock_in);
    #1;
    op_valid_in = 0;
    for (j = 0; j < 40 && done_out !== 1'b1 && illegal_out !== 1'b1; j++) begin
      @(posedge clock_in);
      #1;
    end
    if (i == 40 || j == 40) begin
      n_errors++;
      complete_run();
    end else begin
      check(illegal_out, ill);
    end
  endtask : op
  // register view compare
  task automatic rdchk(input logic [2:0] r, input logic [15:0] exp);
    @(posedge clock_in);
    #1;
    reg_rd_sel_in = r;
    repeat (2) @(posedge clock_in);
    #1;
    check(reg_rd_data_out, exp);
  endtask : rdchk
  // immediate and register moves with flags
  task automatic t_imm();
    op(DTIU_OP_MOVE, 1, DTIU_M_IMM, 0, 4'h1, 4'h0, 16'h8001, 0);
    rdchk(3'h1, 16'h8001);
    check(condition_flags_out, 4'h8);
    op(DTIU_OP_MOVE, 0, DTIU_M_IMM, 0, 4'h9, 4'h0, 16'h3300, 0);
    rdchk(3'h1, 16'h8000);
    check(condition_flags_out, 4'h4);
    op(DTIU_OP_MOVE, 1, DTIU_M_REG, 0, 4'h4, 4'h1, 16'h0000, 0);
    rdchk(3'h4, 16'h8000);
    op(DTIU_OP_MOVE, 1, DTIU_M_IMM, 1, 4'h1, 4'h0, 16'h0000, 1);
    $display("test imm done");
  endtask : t_imm
  // absolute forms, odd word address, short page
  task automatic t_abs();
    op(DTIU_OP_MOVE, 1, DTIU_M_ABS16, 1, 4'h1, 4'h0, 16'h1235, 0);
    check(seen_addr, 16'h1234);
    check(seen_we, 1'b1);
    check(seen_word, 1'b1);
    check(condition_flags_out, 4'h8);
    op(DTIU_OP_MOVE, 0, DTIU_M_ABS8, 1, 4'h1, 4'h0, 16'h0045, 0);
    check(seen_addr, 16'hff45);
    check(seen_word, 1'b0);
    op(DTIU_OP_MOVE, 1, DTIU_M_ABS8, 0, 4'h2, 4'h0, 16'h0045, 1);
    op(DTIU_OP_MOVE, 0, DTIU_M_ABS8, 0, 4'hd, 4'h0, 16'h0045, 0);
    rdchk(3'h5, 16'h0080);
    check(condition_flags_out, 4'h8);
    $display("test abs done");
  endtask : t_abs
  // push and pop with a slow memory
  task automatic t_stack();
    lat = 4'h3;
    op(DTIU_OP_MOVE, 1, DTIU_M_IMM, 0, 4'h7, 4'h0, 16'h0100, 0);
    op(DTIU_OP_PUSH, 1, DTIU_M_PREDEC, 1, 4'h1, 4'h7, 16'h0000, 0);
    check(seen_addr, 16'h00fe);
    check(condition_flags_out, 4'h8);
    rdchk(3'h7, 16'h00fe);
    op(DTIU_OP_POP, 1, DTIU_M_POSTINC, 0, 4'h2, 4'h7, 16'h0000, 0);
    check(seen_addr, 16'h00fe);
    rdchk(3'h2, 16'h8000);
    rdchk(3'h7, 16'h0100);
    lat = 4'h0;
    $display("test stack done");
  endtask : t_stack
  // pointer steps, displacement and refused stack byte form
  task automatic t_ptr();
    op(DTIU_OP_MOVE, 0, DTIU_M_PREDEC, 1, 4'h9, 4'h7, 16'h0000, 1);
    rdchk(3'h7, 16'h0100);
    op(DTIU_OP_MOVE, 1, DTIU_M_IMM, 0, 4'h3, 4'h0, 16'h1234, 0);
    op(DTIU_OP_MOVE, 0, DTIU_M_POSTINC, 0, 4'he, 4'h3, 16'h0000, 0);
    rdchk(3'h3, 16'h1235);
    op(DTIU_OP_MOVE, 1, DTIU_M_DISP, 0, 4'h6, 4'h3, 16'hffff, 0);
    rdchk(3'h6, 16'h8000);
    $display("test ptr done");
  endtask : t_ptr
  // pre-decrement by one and two through an ordinary register, indirect and post-increment loads
  task automatic t_step();
    op(DTIU_OP_MOVE, 0, DTIU_M_PREDEC, 1, 4'h9, 4'h3, 16'h0000, 0);
    check(seen_addr, 16'h1234);
    check(condition_flags_out, 4'h4);
    rdchk(3'h3, 16'h1234);
    op(DTIU_OP_MOVE, 1, DTIU_M_PREDEC, 1, 4'h6, 4'h3, 16'h0000, 0);
    check(seen_addr, 16'h1232);
    check(seen_word, 1'b1);
    check(condition_flags_out, 4'h8);
    rdchk(3'h3, 16'h1232);
    op(DTIU_OP_MOVE, 1, DTIU_M_IND, 0, 4'h0, 4'h3, 16'h0000, 0);
    rdchk(3'h0, 16'h8000);
    op(DTIU_OP_MOVE, 1, DTIU_M_POSTINC, 0, 4'h5, 4'h3, 16'h0000, 0);
    rdchk(3'h3, 16'h1234);
    $display("test step done");
  endtask : t_step
  // reset in mid-run clears registers and flags, then the unit works again
  task automatic t_reset();
    @(posedge clock_in);
    #1;
    rst_in = 1;
    repeat (2) @(posedge clock_in);
    #1;
    rst_in = 0;
    rdchk(3'h3, DTIU_REG_RESET);
    check(condition_flags_out, DTIU_FLAGS_RESET);
    op(DTIU_OP_MOVE, 1, DTIU_M_IMM, 0, 4'h2, 4'h0, 16'h0000, 0);
    check(condition_flags_out, 4'h4);
    rdchk(3'h2, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  // main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    #1;
    rst_in = 0;
    rdchk(3'h7, DTIU_REG_RESET);
    t_imm();
    t_abs();
    t_stack();
    t_ptr();
    t_step();
    t_reset();
    complete_run();
  end
endmodule : tb_top
